// [logic/pim_dma.sv]
/*
  pim_dma: two-channel bus-master dma flow control sharing one pci master port.
  assumes the pci side is on clk and reports dword beats, retry and aborts per cycle;
  drive request and drive interrupt are pins and are synchronised here.
*/
`timescale 1ns/100ps
// How it works
// - inbound: prefetch from drive while waiting; fetch descriptor, then burst buffer out.
// - inbound request when buffer half or full, or irq pending with buffer not empty, while dma active.
// - inbound burst writes two dwords from half buffer, four from full.
// - request drops at first written dword and stays low until buffer drained.
// - write burst ends on burst count, empty buffer, or last descriptor at zero.
// - retry ends write burst; request again at half or full level.
// - count zero early: no more memory writes, bus released, drive prefetch continues.
// - stop then start discards the channel buffer contents.
// - outbound request when buffer empty or half and dma active.
// - outbound burst reads four dwords into empty buffer, two into half.
// - outbound request drops on first stored dword until buffer drained to drive.
// - retry ends read burst; request again at empty or half level.
// - each read beat needs dma active; stop at burst count or end.
// - overlong count: keep reading while allowed; active stays set if data remains.
// - outbound buffer feeds drive as soon as it holds data.
// - count zero, not last: fetch next descriptor; last: release bus.
// - master abort: status bit 13, error, clear active, drop request, flush.
// - target abort: status bit 12, error, clear active, drop request, flush.
// - drive interrupt held while channel runs and buffer not empty or transfer not finished.
module pim_dma #(
  parameter int NCH   = pim_pkg::NCH,
  parameter int DEPTH = pim_pkg::BUF_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [NCH-1:0]       start,
  input  wire logic [NCH-1:0]       dir_in,
  input  wire logic [NCH-1:0][31:0] table_ptr,
  output      logic [NCH-1:0]       active,
  output      logic [NCH-1:0]       error,
  output      logic [NCH-1:0]       channel_irq_pending,
  output      logic [NCH-1:0]       host_irq,
  input  wire logic                 abort_clr,
  output      logic [15:0]          pci_status,
  output      logic                 pci_req,
  output      pim_pkg::pim_mreq_t   mreq,
  input  wire pim_pkg::pim_mrsp_t   mrsp,
  input  wire logic [NCH-1:0]       dmarq,
  output      logic [NCH-1:0]       dmack,
  input  wire logic [NCH-1:0]       drive_irq,
  input  wire logic [NCH-1:0][31:0] drive_in_data,
  input  wire logic [NCH-1:0]       drive_in_valid,
  output      logic [NCH-1:0]       drive_in_ready,
  output      logic [NCH-1:0][31:0] drive_out_data,
  output      logic [NCH-1:0]       drive_out_valid,
  input  wire logic [NCH-1:0]       drive_out_ready
);
  localparam int CW = $clog2(DEPTH) + 1;

  pim_pkg::pim_state_t st_r;
  logic                sel_r;
  logic                rr_r;
  logic [2:0]          beat_r;
  logic [2:0]          len_r;
  logic                frame_r;
  logic                write_r;
  logic [31:0]         addr_r;
  logic                req_r;
  logic [15:0]         stat_r;

  logic [NCH-1:0]       ch_req;
  logic [NCH-1:0]       ch_need_desc;
  logic [NCH-1:0]       ch_dma_act;
  logic [NCH-1:0]       ch_stop_now;
  logic [NCH-1:0]       ch_last_bc;
  logic [NCH-1:0][2:0]  ch_len;
  logic [NCH-1:0][31:0] ch_addr;
  logic [NCH-1:0][31:0] ch_ptr;
  logic [NCH-1:0][31:0] ch_head;
  logic [NCH-1:0][CW-1:0] ch_lvl;

  wire       any_req  = |ch_req;
  wire       pick     = ch_req[1] & (~ch_req[0] | ~rr_r);
  wire       busy     = (st_r == pim_pkg::PIM_DESC) | (st_r == pim_pkg::PIM_DATA);
  wire       in_data  = (st_r == pim_pkg::PIM_DATA);
  wire       beat     = busy & mrsp.ack;
  wire       abort    = busy & (mrsp.mabort | mrsp.tabort);
  wire       last_bt  = (beat_r + 3'h1 == len_r);
  wire       drained  = write_r & (ch_lvl[sel_r] == CW'(1));
  // a beat ends the burst on count, empty buffer (writes only) or last descriptor
  wire       term_bt  = beat & (last_bt | (in_data & (drained | ch_last_bc[sel_r])));
  wire       term_now = in_data & ch_stop_now[sel_r];
  wire       end_burst = term_bt | term_now | (busy & mrsp.retry) | abort;
  wire       go       = (st_r == pim_pkg::PIM_IDLE) & req_r & mrsp.gnt & any_req;

  assign mreq.frame = frame_r;
  assign mreq.write = write_r;
  assign mreq.addr  = addr_r;
  assign mreq.wdata = ch_head[sel_r];
  assign pci_req    = req_r;
  assign pci_status = stat_r;

  // shared master sequencer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r    <= pim_pkg::PIM_IDLE;
      sel_r   <= 1'b0;
      rr_r    <= 1'b0;
      beat_r  <= 3'h0;
      len_r   <= 3'h0;
      frame_r <= 1'b0;
      write_r <= 1'b0;
      addr_r  <= '0;
      req_r   <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        pim_pkg::PIM_IDLE:
        begin
          req_r <= any_req & ~go;
          if (go)
          begin
            sel_r   <= pick;
            rr_r    <= pick;
            beat_r  <= 3'h0;
            frame_r <= 1'b1;
            if (ch_need_desc[pick])
            begin
              st_r    <= pim_pkg::PIM_DESC;
              len_r   <= pim_pkg::DESC_BEATS;
              write_r <= 1'b0;
              addr_r  <= ch_ptr[pick];
            end
            else
            begin
              st_r    <= pim_pkg::PIM_DATA;
              len_r   <= ch_len[pick];
              write_r <= dir_in[pick];
              addr_r  <= ch_addr[pick];
            end
          end
        end
        pim_pkg::PIM_DESC, pim_pkg::PIM_DATA:
        begin
          req_r <= 1'b0;
          if (beat)
          begin
            beat_r <= beat_r + 3'h1;
            addr_r <= addr_r + pim_pkg::ADDR_STEP;
          end
          if (end_burst)
          begin
            st_r    <= pim_pkg::PIM_END;
            frame_r <= 1'b0;
          end
        end
        pim_pkg::PIM_END:
        begin
          st_r <= pim_pkg::PIM_IDLE;
        end
      endcase
    end
  end

  // abort flags: a new abort wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      stat_r <= pim_pkg::STAT_RESET;
    else
    begin
      stat_r[pim_pkg::MABORT_POS] <= (busy & mrsp.mabort) |
                                     (stat_r[pim_pkg::MABORT_POS] & ~abort_clr);
      stat_r[pim_pkg::TABORT_POS] <= (busy & mrsp.tabort) |
                                     (stat_r[pim_pkg::TABORT_POS] & ~abort_clr);
    end
  end

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic [2:0]           rq_s_r;
    logic [2:0]           iq_s_r;
    logic                 rq_lvl_r;
    logic                 iq_lvl_r;
    logic                 start_d_r;
    logic                 run_r;
    logic                 act_r;
    logic                 err_r;
    logic                 dvalid_r;
    logic                 eot_r;
    logic                 hold_r;
    logic                 dmack_r;
    logic                 hirq_r;
    logic [15:0]          bc_r;
    logic [31:0]          addr_r;
    logic [31:0]          ptr_r;
    logic [CW-1:0]        lvl;
    logic                 f_in_ready;
    logic                 f_out_valid;

    wire mine      = (sel_r == 1'(i));
    wire my_beat   = beat & mine;
    wire my_abort  = abort & mine;
    wire desc_bt   = my_beat & (st_r == pim_pkg::PIM_DESC);
    wire data_bt   = my_beat & in_data;
    wire start_rise = start[i] & ~start_d_r;
    wire flush     = start_rise | my_abort;
    wire dma_act   = ~eot_r | (bc_r != '0);
    wire half      = (lvl == CW'(pim_pkg::LVL_HALF));
    wire full      = (lvl == CW'(DEPTH));
    wire empty     = (lvl == '0);
    wire in_req    = half | full | (iq_lvl_r & ~empty);
    wire out_req   = empty | half;
    wire move_ok   = dvalid_r & dma_act & ~hold_r & (dir_in[i] ? in_req : out_req);
    wire fin       = dvalid_r & (bc_r == '0);
    wire f_push    = dir_in[i] ? (drive_in_valid[i] & dmack_r) : (data_bt & ~write_r);
    wire f_pop     = dir_in[i] ? (data_bt & write_r) : (drive_out_ready[i] & dmack_r);
    wire [31:0] f_din = dir_in[i] ? drive_in_data[i] : mrsp.rdata;
    wire [15:0] bc_dec = (bc_r > pim_pkg::BC_STEP) ? bc_r - pim_pkg::BC_STEP : '0;

    assign ch_need_desc[i] = act_r & ~err_r & ~dvalid_r;
    assign ch_req[i]       = act_r & ~err_r & (ch_need_desc[i] | move_ok);
    assign ch_dma_act[i]   = dma_act;
    assign ch_last_bc[i]   = eot_r & (bc_r <= pim_pkg::BC_STEP);
    assign ch_stop_now[i]  = ~dma_act | (write_r ? empty : full);
    assign ch_len[i]       = dir_in[i] ? (full ? pim_pkg::BURST_LONG : pim_pkg::BURST_SHORT)
                                       : (empty ? pim_pkg::BURST_LONG : pim_pkg::BURST_SHORT);
    assign ch_addr[i]      = addr_r;
    assign ch_ptr[i]       = ptr_r;
    assign ch_lvl[i]       = lvl;

    assign active[i]              = act_r;
    assign error[i]               = err_r;
    assign channel_irq_pending[i] = iq_lvl_r;
    assign host_irq[i]            = hirq_r;
    assign dmack[i]               = dmack_r;
    assign drive_in_ready[i]      = dir_in[i] & dmack_r & f_in_ready;
    assign drive_out_valid[i]     = ~dir_in[i] & dmack_r & f_out_valid;

    pim_fifo #(
      .WIDTH (pim_pkg::DW),
      .DEPTH (DEPTH),
      .CW    (CW)
    ) u_buf (
      .clk       (clk),
      .nrst      (nrst),
      .flush     (flush),
      .in_valid  (f_push),
      .in_ready  (f_in_ready),
      .in_data   (f_din),
      .out_valid (f_out_valid),
      .out_ready (f_pop),
      .out_data  (ch_head[i]),
      .level     (lvl)
    );
    assign drive_out_data[i] = ch_head[i];

    // pin inputs: three stages, a level counts once stages two and three agree
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        rq_s_r   <= 3'h0;
        iq_s_r   <= 3'h0;
        rq_lvl_r <= 1'b0;
        iq_lvl_r <= 1'b0;
      end
      else
      begin
        rq_s_r <= {rq_s_r[1:0], dmarq[i]};
        iq_s_r <= {iq_s_r[1:0], drive_irq[i]};
        if (rq_s_r[1] == rq_s_r[2])
          rq_lvl_r <= rq_s_r[2];
        if (iq_s_r[1] == iq_s_r[2])
          iq_lvl_r <= iq_s_r[2];
      end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        start_d_r <= 1'b0;
        run_r     <= 1'b0;
        act_r     <= 1'b0;
        err_r     <= 1'b0;
        dvalid_r  <= 1'b0;
        eot_r     <= 1'b0;
        hold_r    <= 1'b0;
        dmack_r   <= 1'b0;
        hirq_r    <= 1'b0;
        bc_r      <= '0;
        addr_r    <= '0;
        ptr_r     <= '0;
      end
      else
      begin
        start_d_r <= start[i];
        dmack_r   <= run_r & rq_lvl_r & ~my_abort;
        hirq_r    <= iq_lvl_r & ~(run_r & ~(empty & fin & eot_r));
        if (start_rise)
        begin
          run_r    <= 1'b1;
          act_r    <= 1'b1;
          err_r    <= 1'b0;
          dvalid_r <= 1'b0;
          hold_r   <= 1'b0;
          eot_r    <= 1'b0;
          bc_r     <= '0;
          ptr_r    <= table_ptr[i];
        end
        else if (my_abort)
        begin
          run_r  <= 1'b0;
          act_r  <= 1'b0;
          err_r  <= 1'b1;
          hold_r <= 1'b0;
        end
        else if (!start[i])
          run_r <= 1'b0;
        else
        begin
          if (desc_bt && beat_r == 3'h0)
            addr_r <= mrsp.rdata;
          if (desc_bt && beat_r != 3'h0)
          begin
            bc_r     <= mrsp.rdata[pim_pkg::BC_W-1:0];
            eot_r    <= mrsp.rdata[pim_pkg::EOT_POS];
            dvalid_r <= 1'b1;
            ptr_r    <= ptr_r + pim_pkg::DESC_STEP;
          end
          if (data_bt)
          begin
            addr_r <= addr_r + pim_pkg::ADDR_STEP;
            bc_r   <= bc_dec;
          end
          // first dword moved holds the request until the buffer is drained or the burst is retried
          if (data_bt)
            hold_r <= 1'b1;
          else if (empty || (mine && busy && mrsp.retry))
            hold_r <= 1'b0;
          if (fin && !eot_r && !busy)
            dvalid_r <= 1'b0;
          if (fin && eot_r && (dir_in[i] || empty))
            act_r <= 1'b0;
        end
      end
    end
  end
endmodule

// [logic/pim_fifo.sv]
/*
  pim_fifo: channel data buffer with valid/ready on both sides, flush and fill level.
  assumes one clock; flush wins over a push or pop in the same cycle.
*/
`timescale 1ns/100ps
module pim_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data,
  output      logic [CW-1:0]    level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [CW-1:0]    cnt_r;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (cnt_r != CW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign level     = cnt_r;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wr_r] <= in_data;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else if (flush)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= wrap_inc(wr_r);
      if (pop)
        rd_r <= wrap_inc(rd_r);
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end
endmodule

// [shared/pim_pkg.sv]
/*
  pim_pkg: constants, state codes and carrier structs for the bus-master dma flow block.
  assumes a 32-bit pci master port abstracted to dword beats and two drive channels.
*/
package pim_pkg;
  localparam int          NCH         = 2;
  localparam int          DW          = 32;
  localparam int          BUF_DEPTH   = 4;
  localparam int          CNT_W       = 3;
  localparam logic [2:0]  LVL_EMPTY   = 3'h0;
  localparam logic [2:0]  LVL_HALF    = 3'h2;
  localparam logic [2:0]  LVL_FULL    = 3'h4;
  localparam logic [2:0]  BURST_SHORT = 3'h2;
  localparam logic [2:0]  BURST_LONG  = 3'h4;
  localparam logic [2:0]  DESC_BEATS  = 3'h2;
  localparam int          BC_W        = 16;
  localparam logic [15:0] BC_STEP     = 16'h0004;
  localparam logic [31:0] ADDR_STEP   = 32'h0000_0004;
  localparam logic [31:0] DESC_STEP   = 32'h0000_0008;
  localparam int          EOT_POS     = 31;
  localparam int          TABORT_POS  = 12;
  localparam int          MABORT_POS  = 13;
  localparam logic [15:0] STAT_RESET  = 16'h0000;

  typedef enum logic [1:0] {
    PIM_IDLE = 2'b00,
    PIM_DESC = 2'b01,
    PIM_DATA = 2'b11,
    PIM_END  = 2'b10
  } pim_state_t;

  typedef struct packed {
    logic        frame;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pim_mreq_t;

  typedef struct packed {
    logic        gnt;
    logic        ack;
    logic        retry;
    logic        mabort;
    logic        tabort;
    logic [31:0] rdata;
  } pim_mrsp_t;
endpackage

// [verification/pci_ide_busmaster_dma_flow_bench.sv]
/*
  pci_ide_busmaster_dma_flow_bench: self-checking bench for pim_dma with a memory model.
  assumes 50 MHz clock; drive side is played here, inputs change 1 ns after the edge.
*/
`timescale 1ns/100ps
module pci_ide_busmaster_dma_flow_bench;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic [1:0]         start = 2'h0;
  logic [1:0]         dir_in = 2'h0;
  logic [1:0][31:0]   table_ptr = {32'h0000_0200, 32'h0000_0100};
  logic [1:0]         active, error, irq_pend, host_irq, dmack, in_ready, out_valid;
  logic               abort_clr = 1'b0;
  logic [15:0]        pci_status;
  logic               pci_req;
  pim_pkg::pim_mreq_t mreq;
  pim_pkg::pim_mrsp_t mrsp;
  logic [1:0]         dmarq = 2'h0;
  logic [1:0]         drive_irq = 2'h0;
  logic [1:0][31:0]   in_data, out_data;
  logic [1:0]         in_valid = 2'h0;
  logic [1:0]         out_ready = 2'h3;
  logic [1:0]         fault = 2'h0;
  logic               slow = 1'b0;
  logic [31:0]        in_cnt = 32'h0;
  logic [31:0]        wq[$], aq[$], oq[$];
  int                 rbeats = 0;
  int                 err_count = 0;
  int                 n_tests = 0;

  always #10 clk = ~clk;
  assign in_data[0] = 32'hd000_0000 + in_cnt;
  assign in_data[1] = 32'hd000_0000 + in_cnt;

  pim_dma u_pim_dma (.clk(clk), .nrst(nrst), .start(start), .dir_in(dir_in),
    .table_ptr(table_ptr), .active(active), .error(error), .channel_irq_pending(irq_pend),
    .host_irq(host_irq), .abort_clr(abort_clr), .pci_status(pci_status), .pci_req(pci_req),
    .mreq(mreq), .mrsp(mrsp), .dmarq(dmarq), .dmack(dmack), .drive_irq(drive_irq),
    .drive_in_data(in_data), .drive_in_valid(in_valid), .drive_in_ready(in_ready),
    .drive_out_data(out_data), .drive_out_valid(out_valid), .drive_out_ready(out_ready));

  pim_mem_model u_pim_mem_model (.clk(clk), .nrst(nrst), .fault(fault), .slow(slow),
    .pci_req(pci_req), .mreq(mreq), .mrsp(mrsp));

  // record memory beats and drive traffic as seen at the sampling edge
  always @(posedge clk)
  begin
    if (mreq.frame && mrsp.ack && mreq.write)
    begin
      wq.push_back(mreq.wdata);
      aq.push_back(mreq.addr);
    end
    if (mreq.frame && mrsp.ack && !mreq.write)
      rbeats++;
    if (out_valid[0] && out_ready[0])
      oq.push_back(out_data[0]);
    if (in_valid[1] && in_ready[1])
      in_cnt <= in_cnt + 32'h1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic timeout;
    err_count++;
    $display("CHECK FAILED at %0t: wait limit reached", $time);
    end_of_test();
  endtask

  task automatic t_inbound;
    int k;
    dir_in[1] = 1'b1;
    dmarq[1] = 1'b1;
    in_valid[1] = 1'b1;
    start[1] = 1'b1;
    for (k = 0; k < 400 && (wq.size() < 4 || active[1] !== 1'b0); k++)
      step(1);
    if (k == 400)
      timeout();
    step(8);
    check(32'(wq.size()), 32'h4, "memory write count");
    for (k = 0; k < 4; k++)
    begin
      check(wq[k], 32'hd000_0000 + 32'(k), "memory write data");
      check(aq[k], 32'h0000_2000 + 32'(4 * k), "memory write address");
    end
    check({31'h0, active[1]}, 32'h0, "inbound active after last");
    // drive keeps prefetching, so the buffer is not empty: irq must be held
    drive_irq[1] = 1'b1;
    step(6);
    check({31'h0, irq_pend[1]}, 32'h1, "irq pending seen");
    check({31'h0, host_irq[1]}, 32'h0, "irq held while buffer holds data");
    start[1] = 1'b0;
    step(3);
    check({31'h0, host_irq[1]}, 32'h1, "irq passed once channel stopped");
    drive_irq[1] = 1'b0;
    in_valid[1] = 1'b0;
    dmarq[1] = 1'b0;
    step(6);
  endtask

  // flt 1: retries for 20 cycles, then the memory answers with slow beats
  task automatic t_outbound(input logic [1:0] flt);
    int k;
    oq.delete();
    rbeats = 0;
    fault = flt;
    slow = flt[0];
    dmarq[0] = 1'b1;
    start[0] = 1'b1;
    step(20);
    fault = 2'h0;
    for (k = 0; k < 400 && (oq.size() < 4 || active[0] !== 1'b0); k++)
      step(1);
    if (k == 400)
      timeout();
    for (k = 0; k < 4; k++)
      check(oq[k], 32'h0000_1000 + 32'(4 * k), "drive data");
    check(32'(rbeats), 32'h6, "memory read beats");
    check({31'h0, active[0]}, 32'h0, "outbound active after last");
    slow = 1'b0;
    dmarq[0] = 1'b0;
    start[0] = 1'b0;
    step(2);
  endtask

  task automatic t_abort(input logic [1:0] flt, input int bitn);
    int k;
    fault = flt;
    dmarq[0] = 1'b1;
    start[0] = 1'b1;
    // let the start edge clear an error left by an earlier abort
    step(1);
    for (k = 0; k < 100 && error[0] !== 1'b1; k++)
      step(1);
    if (k == 100)
      timeout();
    check(32'(pci_status), 32'h1 << bitn, "abort status");
    check({29'h0, active[0], dmack[0], pci_req}, 32'h0, "abort stops channel");
    fault = 2'h0;
    start[0] = 1'b0;
    dmarq[0] = 1'b0;
    abort_clr = 1'b1;
    step(1);
    abort_clr = 1'b0;
    step(2);
    check(32'(pci_status), 32'h0, "status cleared");
  endtask

  initial
  begin
    step(16);
    nrst = 1'b1;
    step(2);
    t_inbound();
    t_outbound(2'h0);
    t_outbound(2'h1);
    t_abort(2'h2, 13);
    t_abort(2'h3, 12);
    end_of_test();
  end
endmodule

// [verification/pim_dma_chk.sv]
/*
  pim_dma_chk: concurrent checks on the master port of the dma flow block.
  assumes one clock, nrst active low, and the master port response on the same clock.
*/
`timescale 1ns/100ps
module pim_dma_chk #(
  parameter int NCH = 2
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic [NCH-1:0]     error,
  input wire logic [15:0]        pci_status,
  input wire logic               pci_req,
  input wire pim_pkg::pim_mreq_t mreq,
  input wire pim_pkg::pim_mrsp_t mrsp
);
  logic [2:0] beats_r;
  logic [2:0] beats_nxt;

  // dwords moved in the current burst
  assign beats_nxt = mreq.frame ? beats_r + {2'h0, mrsp.ack} : 3'h0;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      beats_r <= 3'h0;
    else
      beats_r <= beats_nxt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_take;
    pci_req && mrsp.gnt && !mreq.frame;
  endsequence
  sequence s_beat_on;
    mreq.frame && mrsp.ack ##1 mreq.frame;
  endsequence
  sequence s_abort;
    mreq.frame && (mrsp.mabort || mrsp.tabort);
  endsequence

  a_grant_starts_frame: assert property (s_take |=> mreq.frame)
    else $error("grant taken but no frame");
  a_no_req_burst: assert property (mreq.frame |-> !pci_req)
    else $error("request raised during a burst");
  a_end_cycle_quiet: assert property ($fell(mreq.frame) |-> !pci_req)
    else $error("request raised in the end cycle");
  a_beat_addr_step: assert property (s_beat_on |-> mreq.addr == $past(mreq.addr) + 32'h4)
    else $error("address did not step by four");
  a_burst_max_four: assert property (beats_r <= 3'h4)
    else $error("burst longer than four dwords");
  a_retry_ends_burst: assert property (mreq.frame && mrsp.retry |=> !mreq.frame [*2])
    else $error("burst kept after retry");
  a_mabort_flags: assert property (mreq.frame && mrsp.mabort |=> pci_status[13] && !pci_req && !mreq.frame)
    else $error("master abort not handled");
  a_tabort_flags: assert property (mreq.frame && mrsp.tabort |=> pci_status[12] && !pci_req && !mreq.frame)
    else $error("target abort not handled");
  a_abort_error: assert property (s_abort |=> (|error))
    else $error("abort without channel error");
endmodule

bind pim_dma pim_dma_chk #(.NCH(NCH)) u_pim_dma_chk (.clk(clk), .nrst(nrst), .error(error),
  .pci_status(pci_status), .pci_req(pci_req), .mreq(mreq), .mrsp(mrsp));

// [verification/pim_mem_model.sv]
/*
  pim_mem_model: arbiter and memory target for the master port.
  assumes descriptor tables below 1000h; fault selects 0 normal, 1 retry, 2 no target, 3 target abort.
*/
`timescale 1ns/100ps
module pim_mem_model (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [1:0]         fault,
  input  wire logic               slow,
  input  wire logic               pci_req,
  input  wire pim_pkg::pim_mreq_t mreq,
  output      pim_pkg::pim_mrsp_t mrsp
);
  logic        gnt_r;
  logic        tog_r;
  logic [31:0] word;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      gnt_r <= 1'b0;
      tog_r <= 1'b0;
    end
    else
    begin
      gnt_r <= pci_req && !mreq.frame;
      tog_r <= !tog_r;
    end

  // eight-byte descriptors: buffer at table*16, then last flag with 16 bytes
  assign word = (mreq.addr[31:12] != 20'h0) ? mreq.addr :
                mreq.addr[2] ? 32'h8000_0010 : {mreq.addr[27:0], 4'h0};
  assign mrsp.gnt    = gnt_r;
  assign mrsp.ack    = mreq.frame && fault == 2'h0 && (!slow || tog_r);
  assign mrsp.retry  = mreq.frame && fault == 2'h1;
  assign mrsp.mabort = mreq.frame && fault == 2'h2;
  assign mrsp.tabort = mreq.frame && fault == 2'h3;
  // no stale data outside a beat
  assign mrsp.rdata  = mrsp.ack ? word : ~mreq.addr;
endmodule
